// ---- hdl/sei2c_pkg.sv ----
// constants shared by the serial eeprom two-wire slave
// assumes a 100 MHz system clock beside the master-driven serial clock
package sei2c_pkg;

  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // largest number of data bytes taken in one write transaction
  localparam logic [3:0] MULTI_MAX = 4'h4;
  localparam logic [3:0] PAGE_MAX = 4'h8;

  // bit slots of the last data bit and of the acknowledge, counted from zero after start
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // self-timed programming time and its length in system clocks
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned TW_MS = 10;
  localparam int unsigned PROG_CYCLES = TW_MS * CLK_KHZ;
  localparam int unsigned PROG_CNT_W = 20;

  // reset values
  localparam logic MODE_RESET = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] CNT_RESET = 4'h0;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SEL  = 6'h02,
    ST_ADDR = 6'h04,
    ST_WR   = 6'h08,
    ST_RD   = 6'h10,
    ST_PROG = 6'h20
  } sei2c_state_t;

endpackage : sei2c_pkg

// ---- hdl/sei2c_slave.sv ----
// two-wire slave of a 256 x 8 serial eeprom with self-timed programming
// assumes SCL and SDA_IN come straight from the bus pins; SDA is resolved outside from SDA_OE
`timescale 1ns/1ps

module sei2c_slave #(
  // value is arbitrary; set it to the identifier wanted on the bus
  parameter logic [6:0] DEVICE_ID = 7'h3C,
  parameter int unsigned PROG_CYCLES = sei2c_pkg::PROG_CYCLES
) (
  // system clock and supply lockout reset
  input wire logic CLK,
  input wire logic RST_B,
  // two-wire bus, serial clock from the master
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // write mode select
  input wire logic MODE
);

  // link domain: capture shift register clocked by the serial clock
  // it shifts on every rise, the acknowledge slot too; the system side picks the byte out
  logic [7:0] link_byte_reg;

  always_ff @(posedge SCL or negedge RST_B)
  begin
    if (!RST_B)
      link_byte_reg <= sei2c_pkg::BYTE_RESET;
    else
      link_byte_reg <= {link_byte_reg[6:0], SDA_IN};
  end

  // system domain synchronisers
  // the third flops only keep a previous sample for the edge detectors
  logic scl_m_reg, scl_s_reg, scl_d_reg;
  logic sda_m_reg, sda_s_reg, sda_d_reg;
  logic mode_m_reg, mode_s_reg;

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      mode_m_reg <= sei2c_pkg::MODE_RESET;
      mode_s_reg <= sei2c_pkg::MODE_RESET;
    end
    else
    begin
      scl_m_reg <= SCL;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= SDA_IN;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
      mode_m_reg <= MODE;
      mode_s_reg <= mode_m_reg;
    end
  end

  sei2c_pkg::sei2c_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [3:0] wr_cnt_reg;
  logic [3:0] commit_idx_reg;
  logic [7:0] addr_reg;
  logic [7:0] rdata_reg;
  logic [7:0] wbuf [0:7];
  logic [7:0] mem [0:sei2c_pkg::MEM_DEPTH-1];
  logic [sei2c_pkg::PROG_CNT_W-1:0] prog_cnt_reg;
  logic ack_reg;
  logic page_mode_reg;

  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic receiving, byte_done, ninth_rise, sel_match, prog_done, commit_busy;
  logic [3:0] wr_limit;

  // one width for the counter, its compare and its step, so none of them is cut silently
  localparam int unsigned PROG_W = sei2c_pkg::PROG_CNT_W;
  localparam logic [PROG_W-1:0] PROG_LAST = PROG_W'(PROG_CYCLES - 1);

  // row-local increment in page mode, full increment otherwise
  function automatic logic [7:0] step_addr(input logic [7:0] base, input logic [3:0] off, input logic page);
    logic [7:0] full;
    full = base + {4'h0, off};
    step_addr = page ? {base[7:3], full[2:0]} : full;
  endfunction : step_addr

  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  assign start_ev = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_ev = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  assign receiving = (state_reg == sei2c_pkg::ST_SEL) || (state_reg == sei2c_pkg::ST_ADDR) ||
                     (state_reg == sei2c_pkg::ST_WR);
  // link byte is stable here: it next changes on a later serial clock rise
  assign byte_done = scl_rise && receiving && (bit_cnt_reg == sei2c_pkg::LAST_DATA_BIT);
  assign ninth_rise = scl_rise && (bit_cnt_reg == sei2c_pkg::ACK_BIT);
  assign sel_match = (link_byte_reg[7:1] == DEVICE_ID);
  assign wr_limit = page_mode_reg ? sei2c_pkg::PAGE_MAX : sei2c_pkg::MULTI_MAX;
  assign prog_done = (prog_cnt_reg == PROG_LAST);
  assign commit_busy = (state_reg == sei2c_pkg::ST_PROG) && (commit_idx_reg < wr_cnt_reg);

  // transaction state; lockout reset holds idle and releases into idle
  // a start outside programming restarts decoding, even in the middle of a byte
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      state_reg <= sei2c_pkg::ST_IDLE;
    else if (state_reg == sei2c_pkg::ST_PROG)
    begin
      if (prog_done)
        state_reg <= sei2c_pkg::ST_IDLE;
    end
    else if (start_ev)
      state_reg <= sei2c_pkg::ST_SEL;
    else if (stop_ev)
      state_reg <= ((state_reg == sei2c_pkg::ST_WR) && (wr_cnt_reg != 4'h0)) ?
                   sei2c_pkg::ST_PROG : sei2c_pkg::ST_IDLE;
    else if (byte_done && (state_reg == sei2c_pkg::ST_SEL))
    begin
      if (!sel_match)
        state_reg <= sei2c_pkg::ST_IDLE;
      else if (link_byte_reg[0])
        state_reg <= sei2c_pkg::ST_RD;
      else
        state_reg <= sei2c_pkg::ST_ADDR;
    end
    else if (byte_done && (state_reg == sei2c_pkg::ST_ADDR))
      state_reg <= sei2c_pkg::ST_WR;
    else if (ninth_rise && (state_reg == sei2c_pkg::ST_RD) && !ack_reg && sda_s_reg)
      state_reg <= sei2c_pkg::ST_IDLE;
  end

  // bit slot counter, 0..7 data and 8 acknowledge
  // counts synchronised rises, so it trails the link register by a few system clocks
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      bit_cnt_reg <= sei2c_pkg::CNT_RESET;
    else if (start_ev || (state_reg == sei2c_pkg::ST_IDLE) || (state_reg == sei2c_pkg::ST_PROG))
      bit_cnt_reg <= sei2c_pkg::CNT_RESET;
    else if (scl_rise)
      bit_cnt_reg <= (bit_cnt_reg == sei2c_pkg::ACK_BIT) ? sei2c_pkg::CNT_RESET : bit_cnt_reg + 4'h1;
  end

  // acknowledge decision for the coming ninth slot
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      ack_reg <= 1'b0;
    else if (start_ev || stop_ev || ninth_rise || (state_reg == sei2c_pkg::ST_PROG))
      ack_reg <= 1'b0;
    else if (byte_done)
    begin
      unique case (state_reg)
        sei2c_pkg::ST_SEL: ack_reg <= sel_match;
        sei2c_pkg::ST_ADDR: ack_reg <= 1'b1;
        sei2c_pkg::ST_WR: ack_reg <= (wr_cnt_reg < wr_limit);
        default: ack_reg <= 1'b0;
      endcase
    end
  end

  // write mode caught from the live pin at each select byte
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      page_mode_reg <= ~sei2c_pkg::MODE_RESET;
    else if (byte_done && (state_reg == sei2c_pkg::ST_SEL))
      page_mode_reg <= ~mode_s_reg;
  end

  // write latches; bytes past the mode limit are refused and not stored
  // a start during programming keeps the count, which the commit still needs
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      wr_cnt_reg <= sei2c_pkg::CNT_RESET;
    else if (start_ev && (state_reg != sei2c_pkg::ST_PROG))
      wr_cnt_reg <= sei2c_pkg::CNT_RESET;
    else if ((state_reg == sei2c_pkg::ST_PROG) && prog_done)
      wr_cnt_reg <= sei2c_pkg::CNT_RESET;
    else if (byte_done && (state_reg == sei2c_pkg::ST_WR) && (wr_cnt_reg < wr_limit))
      wr_cnt_reg <= wr_cnt_reg + 4'h1;
  end

  always_ff @(posedge CLK)
  begin
    if (byte_done && (state_reg == sei2c_pkg::ST_WR) && (wr_cnt_reg < wr_limit))
      wbuf[wr_cnt_reg[2:0]] <= link_byte_reg;
  end

  // byte address: loaded, stepped by reads, moved past the written bytes after programming
  // a refused last read byte still steps it, so a current read follows on
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      addr_reg <= sei2c_pkg::BYTE_RESET;
    else if (byte_done && (state_reg == sei2c_pkg::ST_ADDR))
      addr_reg <= link_byte_reg;
    else if (ninth_rise && (state_reg == sei2c_pkg::ST_RD) && !ack_reg)
      addr_reg <= addr_reg + 8'h01;
    else if ((state_reg == sei2c_pkg::ST_PROG) && prog_done)
      addr_reg <= step_addr(addr_reg, wr_cnt_reg, page_mode_reg);
  end

  // read data for the byte being shifted out
  // prefetched one byte ahead so its first bit is ready at the next falling clock
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rdata_reg <= sei2c_pkg::BYTE_RESET;
    else if (byte_done && (state_reg == sei2c_pkg::ST_SEL))
      rdata_reg <= mem[addr_reg];
    else if (ninth_rise && (state_reg == sei2c_pkg::ST_RD) && !ack_reg)
      rdata_reg <= mem[addr_reg + 8'h01];
  end

  // self-timed programming: commit one latch per clock, then wait out the cycle
  // the wait is fixed in length, whatever the number of latched bytes
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      prog_cnt_reg <= '0;
      commit_idx_reg <= sei2c_pkg::CNT_RESET;
    end
    else if (state_reg == sei2c_pkg::ST_PROG)
    begin
      prog_cnt_reg <= prog_cnt_reg + PROG_W'(1);
      if (commit_busy)
        commit_idx_reg <= commit_idx_reg + 4'h1;
    end
    else
    begin
      prog_cnt_reg <= '0;
      commit_idx_reg <= sei2c_pkg::CNT_RESET;
    end
  end

  // array content is data, left without reset
  always_ff @(posedge CLK)
  begin
    if (commit_busy)
      mem[step_addr(addr_reg, commit_idx_reg, page_mode_reg)] <= wbuf[commit_idx_reg[2:0]];
  end

  // open-drain data drive, changed only after a falling serial clock
  // a start or stop releases the wire at once, whatever slot was in progress
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      SDA_OE <= 1'b0;
    else if (start_ev || stop_ev || (state_reg == sei2c_pkg::ST_IDLE) || (state_reg == sei2c_pkg::ST_PROG))
      SDA_OE <= 1'b0;
    else if (scl_fall)
    begin
      if (bit_cnt_reg == sei2c_pkg::ACK_BIT)
        SDA_OE <= ack_reg;
      else
        SDA_OE <= (state_reg == sei2c_pkg::ST_RD) && !rdata_reg[3'(7 - bit_cnt_reg[2:0])];
    end
  end

  // the pin level when enabled is always low; clock is never driven
  // kept in a flop so that both pin controls leave the block from registers
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      SDA_OUT <= 1'b0;
    else
      SDA_OUT <= 1'b0;
  end

endmodule : sei2c_slave

// ---- tb/sei2c_monitor.sv ----
// pin assertions for the two-wire eeprom slave
// assumes serial clock phases of many system clocks
`timescale 1ns/1ps
module sei2c_monitor (
  // system
  input wire logic CLK,
  input wire logic RST_B,
  // bus
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE
);
  logic scl_reg;
  logic sda_reg;
  logic started_reg;
  logic [3:0] lo_cnt_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  always_ff @(posedge CLK)
  begin
    scl_reg <= SCL;
    sda_reg <= SDA_IN;
  end
  // cleared by lockout so no start carries over a reset
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
      started_reg <= 1'b0;
    else if (SCL && scl_reg && sda_reg && !SDA_IN)
      started_reg <= 1'b1;
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
      lo_cnt_reg <= 4'h0;
    else if (SCL)
      lo_cnt_reg <= 4'h0;
    else if (lo_cnt_reg != 4'hF)
      lo_cnt_reg <= lo_cnt_reg + 4'h1;
  sequence s_start; SCL && $past(SCL) && $fell(SDA_IN); endsequence
  sequence s_stop; SCL && $past(SCL) && $rose(SDA_IN); endsequence
  property p_sda_low; SDA_OUT == 1'b0; endproperty
  property p_lock_quiet; $rose(RST_B) |-> !SDA_OE ##1 !SDA_OE; endproperty
  property p_idle; !started_reg |-> !SDA_OE; endproperty
  property p_rise_low; $rose(SDA_OE) |-> !SCL; endproperty
  property p_latency; $changed(SDA_OE) && !SCL |-> lo_cnt_reg inside {[4'h2:4'h7]}; endproperty
  property p_stands; $rose(SDA_OE) |-> SDA_OE [*8]; endproperty
  property p_hold_high; $rose(SCL) |-> $stable(SDA_OE) [*4]; endproperty
  property p_start_quiet; s_start |-> !SDA_OE [*8]; endproperty
  property p_stop_rel; s_stop |-> ##[0:6] !SDA_OE; endproperty
  a_sda_low: assert property (p_sda_low) else $error("data driven high");
  a_lock_quiet: assert property (p_lock_quiet) else $error("pull after lockout");
  a_idle: assert property (p_idle) else $error("pull before start");
  a_rise_low: assert property (p_rise_low) else $error("pull in clock high");
  a_latency: assert property (p_latency) else $error("bad pull timing");
  a_stands: assert property (p_stands) else $error("pull too short");
  a_hold_high: assert property (p_hold_high) else $error("change in clock high");
  a_start_quiet: assert property (p_start_quiet) else $error("pull after start");
  a_stop_rel: assert property (p_stop_rel) else $error("no release at stop");
endmodule : sei2c_monitor
bind sei2c_slave sei2c_monitor u_mon (.CLK(CLK), .RST_B(RST_B), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));

// ---- tb/sei2c_master.sv ----
// bus master model: drives the serial clock and pulls the data wire
// assumes the bench resolves the open-drain wire with a pull-up
`timescale 1ns/1ps
module sei2c_master (
  // link clock
  input wire logic lclk,
  // bus
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // clock parks high between frames
  initial scl = 1'b1;
  initial sda_oe = 1'b0;
  task automatic half();
    repeat (16) @(posedge lclk);
    #1;
  endtask : half
  // data moves only a half phase after the clock falls
  task automatic ph(input logic s, input logic o);
    half();
    scl = s;
    sda_oe = o;
  endtask : ph
  task automatic start();
    ph(scl, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask : start
  task automatic stop();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    half();
  endtask : stop
  task automatic bitx(input logic b, output logic r);
    ph(1'b0, ~b);
    ph(1'b1, ~b);
    half();
    r = sda;
    scl = 1'b0;
  endtask : bitx
  // ack_in 1 releases the ninth slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(ack_in, ack);
  endtask : xfer
endmodule : sei2c_master

// ---- tb/tb.sv ----
// bench for the two-wire eeprom slave with a master model on the link clock
// assumes a shortened programming time
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb;
  // value is arbitrary
  localparam logic [6:0] DEV_ID = 7'h2B;
  localparam int PROG = 2000;
  logic CLK = 1'b0;
  logic LCLK = 1'b0;
  logic RST_B = 1'b0;
  logic MODE = 1'b1;
  logic SCL;
  logic m_oe;
  logic SDA_OUT;
  logic SDA_OE;
  logic [7:0] exp_mem [256];
  logic [7:0] cur;
  int err_count = 0;
  int check_count = 0;
  wire SDA_IN = ~m_oe & (SDA_OE ? SDA_OUT : 1'b1);
  always #5 CLK = ~CLK;
  always #7.5 LCLK = ~LCLK;
  sei2c_slave #(.DEVICE_ID(DEV_ID), .PROG_CYCLES(PROG)) u_dut (.CLK(CLK), .RST_B(RST_B), .SCL(SCL),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .MODE(MODE));
  sei2c_master u_mst (.lclk(LCLK), .scl(SCL), .sda_oe(m_oe), .sda(SDA_IN));
  task automatic drive(input logic r, input logic m);
    @(posedge CLK) #1;
    RST_B = r;
    MODE = m;
  endtask : drive
  task automatic put(input logic [7:0] d, input logic ea);
    logic [7:0] q;
    logic ak;
    u_mst.xfer(d, 1'b1, q, ak);
    `CHK(ak, ea)
  endtask : put
  task automatic sel(input logic r, input logic ea);
    u_mst.start();
    put({DEV_ID, r}, ea);
  endtask : sel
  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0);
    logic [7:0] p;
    int lim;
    lim = MODE ? 4 : 8;
    p = a;
    sel(1'b0, 1'b0);
    put(a, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      put(d0 + 8'(i), (i < lim) ? 1'b0 : 1'b1);
      if (i < lim)
      begin
        exp_mem[p] = d0 + 8'(i);
        p = MODE ? p + 8'h1 : {p[7:3], p[2:0] + 3'h1};
      end
    end
    u_mst.stop();
    cur = p;
  endtask : wr
  // busy device ignores the poll, then is left to finish
  task automatic prog_wait();
    sel(1'b0, 1'b1);
    u_mst.stop();
    repeat (PROG) @(posedge CLK);
  endtask : prog_wait
  task automatic rd(input logic rnd, input logic [7:0] a, input int n);
    logic [7:0] q;
    logic ak;
    if (rnd)
    begin
      sel(1'b0, 1'b0);
      put(a, 1'b0);
      cur = a;
    end
    sel(1'b1, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      u_mst.xfer(8'hFF, (i == n - 1), q, ak);
      `CHK(q, exp_mem[cur])
      cur = cur + 8'h1;
    end
    u_mst.stop();
  endtask : rd
  task automatic t_lockout();
    drive(1'b0, 1'b1);
    sel(1'b0, 1'b1);
    u_mst.stop();
    drive(1'b1, 1'b1);
    repeat (4) @(posedge CLK);
    sel(1'b0, 1'b0);
    drive(1'b0, 1'b1);
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    put(8'h00, 1'b1);
    u_mst.stop();
    $display("test lockout done");
  endtask : t_lockout
  task automatic t_multi();
    u_mst.start();
    put({~DEV_ID, 1'b0}, 1'b1);
    u_mst.stop();
    wr(8'hFE, 5, 8'hA0);
    prog_wait();
    rd(1'b1, 8'hFE, 4);
    $display("test multibyte done");
  endtask : t_multi
  task automatic t_page();
    drive(1'b1, 1'b0);
    wr(8'h35, 9, 8'h50);
    prog_wait();
    rd(1'b0, cur, 1);
    rd(1'b1, 8'h30, 8);
    wr(8'h10, 1, 8'h77);
    prog_wait();
    rd(1'b1, 8'h10, 1);
    $display("test page done");
  endtask : t_page
  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (19) @(posedge CLK);
    drive(1'b1, 1'b1);
    t_lockout();
    t_multi();
    t_page();
    final_report();
  end
  initial
  begin
    #800000;
    err_count++;
    final_report();
  end
endmodule : tb
